/* common/lsc_pkg.sv */
// Package for the light sensor control register block
package lsc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_POWER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GAIN_AND_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_LOW_LIMIT_LSB = 4'h2;
  localparam logic [3:0] ADDR_LOW_LIMIT_MSB = 4'h3;
  localparam logic [3:0] ADDR_HIGH_LIMIT_LSB = 4'h4;
  localparam logic [3:0] ADDR_HIGH_LIMIT_MSB = 4'h5;
  localparam logic [3:0] ADDR_ALERT_CONTROL = 4'h6;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_GAIN_PERIOD = 8'h02;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_ALERT = 8'h00;
  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int PTR_CMD_BIT = 7;
  localparam int PTR_CLEAR_BIT = 6;
  localparam int PTR_WORD_BIT = 5;
  localparam int GP_GAIN_BIT = 4;
  localparam int GP_MANUAL_BIT = 3;
  localparam logic [1:0] POWER_UP = 2'h3;
  localparam logic [1:0] POWER_DOWN = 2'h0;
  localparam logic [1:0] PERIOD_SHORT = 2'h0;
  localparam logic [1:0] PERIOD_MID = 2'h1;
  localparam logic [1:0] PERIOD_LONG = 2'h2;
  localparam logic [1:0] PERIOD_MANUAL = 2'h3;
  localparam logic [1:0] ALERT_OFF = 2'h0;
  localparam logic [1:0] ALERT_LEVEL = 2'h1;
  localparam logic [7:0] MASK_POWER = 8'h03;
  localparam logic [7:0] MASK_GAIN_PERIOD = 8'h1B;
  localparam logic [7:0] MASK_ALERT = 8'h3F;
  // ----------------------------------------
  // Bus addresses per strap level
  // ----------------------------------------
  localparam logic [6:0] BUS_ADDR_GND = 7'h29;
  localparam logic [6:0] BUS_ADDR_FLOAT = 7'h39;
  localparam logic [6:0] BUS_ADDR_VDD = 7'h49;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam real TINT_SHORT_MS = 13.7;
  localparam real TINT_MID_MS = 101.0;
  localparam real TINT_LONG_MS = 402.0;
  localparam int CYC_SHORT = int'($floor(TINT_SHORT_MS * CLK_HZ / 1000.0));
  localparam int CYC_MID = int'($floor(TINT_MID_MS * CLK_HZ / 1000.0));
  localparam int CYC_LONG = int'($floor(TINT_LONG_MS * CLK_HZ / 1000.0));

  typedef enum logic [1:0] {LSC_STRAP_GND, LSC_STRAP_FLOAT, LSC_STRAP_VDD} lsc_strap_t;

  // Byte written by the bus engine
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } lsc_wbyte_t;

  // Pointer byte fields
  typedef struct packed {
    logic cmd;
    logic clear;
    logic word;
    logic rsvd;
    logic [3:0] addr;
  } lsc_ptr_t;
endpackage

/* verilog/lsc_regs.sv */
// Control and status registers of a two-channel light sensor
//
// Function
// - Pointer bit 6 clears pending alert; bit reads back zero.
// - Pointer bit 5 flags word write or word read transaction.
// - Pointer bits 3:0 select target register for data access.
// - Pointer loaded by send-byte; resets to zero.
// - Power field 03h powers up, 00h powers down.
// - Power register reads back 03h after 03h written.
// - Gain and period register resets to 02h.
// - Gain bit 4: zero is 1x, one is 16x.
// - One gain and period setting drives both channels.
// - Period field picks 13.7, 101, 402 ms or manual.
// - Manual bit starts/stops integration only when period is 11.
// - Channel 0 at or below low limit is below window.
// - Channel 0 above high limit is above window.
// - Offsets 2h-5h hold two 16-bit limits, reset 00h.
// - Alert mode 00 disables output, 01 selects level.
// - Persistence 0000 alerts after every integration.
// - Persistence N alerts after N consecutive out-of-window results.
// - Alert pin active low, held until pointer clear bit written or alert mode set to 00.
// - Any byte with top bit set is a pointer byte.
// - Completed integration latches both results, next starts itself in timed periods only.
// - Bus address taken from strap once, in the first cycle after reset: 29h, 39h or 49h.
`timescale 1ns/10ps
module lsc_regs
  import lsc_pkg::*;
#(
  parameter int CYCLES_SHORT = CYC_SHORT,
  parameter int CYCLES_MID = CYC_MID,
  parameter int CYCLES_LONG = CYC_LONG
) (
  input wire logic mclk,
  input wire logic rst,
  input wire lsc_strap_t strap,
  input wire lsc_wbyte_t wr_byte,
  input wire logic rd_pulse,
  input wire logic [15:0] adc_ch0,
  input wire logic [15:0] adc_ch1,
  output logic [7:0] rd_data,
  output logic [6:0] bus_addr,
  output logic word_mode,
  output logic powered,
  output logic high_gain,
  output logic integrating,
  output logic conv_done,
  output logic [15:0] data_ch0,
  output logic [15:0] data_ch1,
  output logic alert_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ptr_ff, nxt_ptr;
  logic [1:0] pwr_ff, nxt_pwr;
  logic pwr_up_ff, nxt_pwr_up;
  logic [7:0] gp_ff, nxt_gp;
  logic [7:0] lim_ff [4], nxt_lim [4];
  logic [7:0] alc_ff, nxt_alc;
  logic [7:0] rd_ff, nxt_rd;
  logic [6:0] addr_ff, nxt_addr;
  logic addr_done_ff, nxt_addr_done;
  logic [31:0] tcnt_ff, nxt_tcnt;
  logic integ_ff, nxt_integ;
  logic done_ff, nxt_done;
  logic [15:0] d0_ff, nxt_d0, d1_ff, nxt_d1;
  logic [3:0] pcnt_ff, nxt_pcnt;
  logic pend_ff, nxt_pend;
  logic alert_n_ff, nxt_alert_n;

  lsc_ptr_t ptr_in;
  logic is_ptr, is_data, end_integ, outside;
  logic [15:0] low_lim, high_lim;
  logic [31:0] target;

  assign ptr_in = lsc_ptr_t'(wr_byte.data);
  assign is_ptr = wr_byte.valid && ptr_in.cmd;
  assign is_data = wr_byte.valid && !ptr_in.cmd;
  assign low_lim = {lim_ff[1], lim_ff[0]};
  assign high_lim = {lim_ff[3], lim_ff[2]};

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_pwr = pwr_ff;
    nxt_gp = gp_ff;
    nxt_alc = alc_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_lim[i] = lim_ff[i];
    end
    if (is_ptr) begin
      // Clear bit never stored
      nxt_ptr = wr_byte.data & ~(8'h01 << PTR_CLEAR_BIT);
    end else if (is_data) begin
      unique case (ptr_ff[3:0])
        ADDR_POWER_CONTROL: nxt_pwr = wr_byte.data[1:0];
        ADDR_GAIN_AND_PERIOD: nxt_gp = wr_byte.data & MASK_GAIN_PERIOD;
        ADDR_LOW_LIMIT_LSB: nxt_lim[0] = wr_byte.data;
        ADDR_LOW_LIMIT_MSB: nxt_lim[1] = wr_byte.data;
        ADDR_HIGH_LIMIT_LSB: nxt_lim[2] = wr_byte.data;
        ADDR_HIGH_LIMIT_MSB: nxt_lim[3] = wr_byte.data;
        ADDR_ALERT_CONTROL: nxt_alc = wr_byte.data & MASK_ALERT;
        default: nxt_ptr = ptr_ff;
      endcase
      // Word access steps to the paired byte
      if (ptr_ff[PTR_WORD_BIT] && wr_byte.first) begin
        nxt_ptr[3:0] = ptr_ff[3:0] + 4'h1;
      end
    end
    // Registered power flag keeps the output on a flop
    nxt_pwr_up = (nxt_pwr == POWER_UP);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_ff <= RST_POINTER;
      pwr_ff <= RST_POWER[1:0];
      pwr_up_ff <= 1'b0;
      gp_ff <= RST_GAIN_PERIOD;
      alc_ff <= RST_ALERT;
      for (int i = 0; i < 4; i++) begin
        lim_ff[i] <= RST_LIMIT;
      end
    end else begin
      ptr_ff <= nxt_ptr;
      pwr_ff <= nxt_pwr;
      pwr_up_ff <= nxt_pwr_up;
      gp_ff <= nxt_gp;
      alc_ff <= nxt_alc;
      for (int i = 0; i < 4; i++) begin
        lim_ff[i] <= nxt_lim[i];
      end
    end
  end

  // ----------------------------------------
  // Read path and bus address
  // ----------------------------------------
  always_comb begin
    nxt_rd = rd_ff;
    if (rd_pulse || is_ptr) begin
      unique case (is_ptr ? ptr_in.addr : ptr_ff[3:0])
        ADDR_POWER_CONTROL: nxt_rd = {6'h00, pwr_ff};
        ADDR_GAIN_AND_PERIOD: nxt_rd = gp_ff;
        ADDR_LOW_LIMIT_LSB: nxt_rd = lim_ff[0];
        ADDR_LOW_LIMIT_MSB: nxt_rd = lim_ff[1];
        ADDR_HIGH_LIMIT_LSB: nxt_rd = lim_ff[2];
        ADDR_HIGH_LIMIT_MSB: nxt_rd = lim_ff[3];
        ADDR_ALERT_CONTROL: nxt_rd = alc_ff;
        default: nxt_rd = 8'h00;
      endcase
    end
    nxt_addr = addr_ff;
    nxt_addr_done = 1'b1;
    if (!addr_done_ff) begin
      unique case (strap)
        LSC_STRAP_GND: nxt_addr = BUS_ADDR_GND;
        LSC_STRAP_FLOAT: nxt_addr = BUS_ADDR_FLOAT;
        LSC_STRAP_VDD: nxt_addr = BUS_ADDR_VDD;
        default: nxt_addr = BUS_ADDR_FLOAT;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_ff <= 8'h00;
      addr_ff <= BUS_ADDR_FLOAT;
      addr_done_ff <= 1'b0;
    end else begin
      rd_ff <= nxt_rd;
      addr_ff <= nxt_addr;
      addr_done_ff <= nxt_addr_done;
    end
  end

  // ----------------------------------------
  // Integration timer
  // ----------------------------------------
  always_comb begin
    unique case (gp_ff[1:0])
      PERIOD_SHORT: target = 32'(CYCLES_SHORT);
      PERIOD_MID: target = 32'(CYCLES_MID);
      PERIOD_LONG: target = 32'(CYCLES_LONG);
      PERIOD_MANUAL: target = 32'h0;
    endcase
    nxt_tcnt = tcnt_ff;
    nxt_integ = integ_ff;
    end_integ = 1'b0;
    if (pwr_ff != POWER_UP) begin
      nxt_tcnt = 32'h0;
      nxt_integ = 1'b0;
    end else if (gp_ff[1:0] == PERIOD_MANUAL) begin
      nxt_integ = gp_ff[GP_MANUAL_BIT];
      end_integ = integ_ff && !gp_ff[GP_MANUAL_BIT];
      nxt_tcnt = 32'h0;
    end else begin
      nxt_integ = 1'b1;
      if (tcnt_ff + 32'h1 >= target) begin
        end_integ = 1'b1;
        nxt_tcnt = 32'h0;
      end else begin
        nxt_tcnt = tcnt_ff + 32'h1;
      end
    end
    nxt_done = end_integ;
    nxt_d0 = end_integ ? adc_ch0 : d0_ff;
    nxt_d1 = end_integ ? adc_ch1 : d1_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tcnt_ff <= 32'h0;
      integ_ff <= 1'b0;
      done_ff <= 1'b0;
      d0_ff <= 16'h0000;
      d1_ff <= 16'h0000;
    end else begin
      tcnt_ff <= nxt_tcnt;
      integ_ff <= nxt_integ;
      done_ff <= nxt_done;
      d0_ff <= nxt_d0;
      d1_ff <= nxt_d1;
    end
  end

  // ----------------------------------------
  // Alert logic
  // ----------------------------------------
  assign outside = (adc_ch0 <= low_lim) || (adc_ch0 > high_lim);

  always_comb begin
    nxt_pcnt = pcnt_ff;
    nxt_pend = pend_ff;
    if (is_ptr && ptr_in.clear) begin
      nxt_pend = 1'b0;
    end
    if (end_integ) begin
      if (alc_ff[3:0] == 4'h0) begin
        nxt_pend = 1'b1;
      end else if (!outside) begin
        nxt_pcnt = 4'h0;
      end else begin
        if (pcnt_ff != 4'hF) begin
          nxt_pcnt = pcnt_ff + 4'h1;
        end
        if (pcnt_ff + 4'h1 >= alc_ff[3:0]) begin
          nxt_pend = 1'b1;
        end
      end
    end
    // Set wins over a clear in the same cycle
    nxt_alert_n = !(nxt_pend && alc_ff[5:4] == ALERT_LEVEL);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcnt_ff <= 4'h0;
      pend_ff <= 1'b0;
      alert_n_ff <= 1'b1;
    end else begin
      pcnt_ff <= nxt_pcnt;
      pend_ff <= nxt_pend;
      alert_n_ff <= nxt_alert_n;
    end
  end

  assign rd_data = rd_ff;
  assign bus_addr = addr_ff;
  assign word_mode = ptr_ff[PTR_WORD_BIT];
  assign powered = pwr_up_ff;
  assign high_gain = gp_ff[GP_GAIN_BIT];
  assign integrating = integ_ff;
  assign conv_done = done_ff;
  assign data_ch0 = d0_ff;
  assign data_ch1 = d1_ff;
  assign alert_n = alert_n_ff;
endmodule

/* sim/lsc_regs_assertions.sv */
// Port checks for the light sensor register block
`timescale 1ns/10ps
module lsc_regs_assertions
  import lsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire lsc_strap_t strap,
  input wire lsc_wbyte_t wr_byte,
  input wire logic word_mode,
  input wire logic powered,
  input wire logic integrating,
  input wire logic conv_done,
  input wire logic [15:0] data_ch0,
  input wire logic [6:0] bus_addr,
  input wire logic alert_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_ptr;
    wr_byte.valid && wr_byte.data[7];
  endsequence
  sequence s_clr;
    s_ptr ##0 wr_byte.data[6];
  endsequence
  a_alert_on_done: assert property ($fell(alert_n) |-> conv_done || $past(wr_byte.valid, 2))
    else $error("alert fell outside a conversion end");
  a_alert_holds: assert property (!alert_n && !wr_byte.valid && !$past(wr_byte.valid) |=> !alert_n)
    else $error("alert released without a clear");
  a_clear_frees: assert property (s_clr |=> alert_n || conv_done)
    else $error("clear did not release alert");
  a_done_single: assert property (conv_done |=> !conv_done)
    else $error("conversion end longer than one cycle");
  a_word_follows: assert property (s_ptr |=> word_mode == $past(wr_byte.data[5]))
    else $error("word flag does not follow pointer");
  a_integ_power: assert property ($rose(integrating) |-> powered)
    else $error("integration started while powered down");
  a_data_on_done: assert property ($changed(data_ch0) |-> conv_done || $past(conv_done))
    else $error("result changed outside a conversion end");
  a_addr_strap: assert property (!$past(rst) |-> bus_addr ==
    (strap == LSC_STRAP_GND ? BUS_ADDR_GND : strap == LSC_STRAP_VDD ? BUS_ADDR_VDD : BUS_ADDR_FLOAT))
    else $error("bus address does not match strap");
endmodule

/* sim/lsc_host.sv */
// Host side byte engine model
`timescale 1ns/10ps
module lsc_host
  import lsc_pkg::*;
(
  input wire logic mclk,
  output lsc_wbyte_t wr_byte,
  output logic rd_pulse
);
  initial begin
    wr_byte = '0;
    rd_pulse = 1'b0;
  end
  task automatic put(input logic f, input logic [7:0] d);
    @(posedge mclk) #2;
    wr_byte = '{1'b1, f, d};
    @(posedge mclk) #2;
    wr_byte = '0;
  endtask
  task automatic ptr(input logic c, input logic w, input logic [3:0] a);
    put(1'b0, {1'b1, c, w, 1'b0, a});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ptr(1'b0, 1'b0, a);
    put(1'b1, d);
  endtask
  task automatic wrw(input logic [3:0] a, input logic [15:0] d);
    ptr(1'b0, 1'b1, a);
    put(1'b1, d[7:0]);
    put(1'b0, d[15:8]);
  endtask
  task automatic rd();
    @(posedge mclk) #2;
    rd_pulse = 1'b1;
    @(posedge mclk) #2;
    rd_pulse = 1'b0;
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the light sensor register block
`timescale 1ns/10ps
module tb_top;
  import lsc_pkg::*;
  logic mclk, rst, rp, wm, pw, hg, itg, done, al_n, g;
  logic rd_q = 1'b0;
  logic [15:0] ch0, ch1, d0, d1;
  logic [31:0] lim;
  logic [7:0] rdat;
  logic [6:0] ba;
  lsc_wbyte_t wb;
  logic [7:0] exp_q[$];
  int fails = 0;
  int compares = 0;
  int n;
  lsc_host i_lsc_host (.mclk(mclk), .wr_byte(wb), .rd_pulse(rp));
  lsc_regs #(.CYCLES_SHORT(20), .CYCLES_MID(40), .CYCLES_LONG(80)) i_lsc_regs (
    .mclk(mclk), .rst(rst), .strap(LSC_STRAP_GND), .wr_byte(wb), .rd_pulse(rp),
    .adc_ch0(ch0), .adc_ch1(ch1), .rd_data(rdat), .bus_addr(ba), .word_mode(wm),
    .powered(pw), .high_gain(hg), .integrating(itg), .conv_done(done),
    .data_ch0(d0), .data_ch1(d1), .alert_n(al_n));
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    compares++;
    if (v !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    i_lsc_host.ptr(1'b0, 1'b0, a);
    exp_q.push_back(e);
    i_lsc_host.rd();
  endtask
  task automatic wdone();
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge mclk) #2;
      n++;
    end
    chk(n < 300, 1'b1);
    @(posedge mclk) #2;
  endtask
  always @(posedge mclk) begin
    if (rd_q) chk(rdat, exp_q.pop_front());
    rd_q <= rp;
  end
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #500000;
    fails++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    ch0 = '0;
    ch1 = '0;
    void'($urandom(5716));
    repeat (16) @(posedge mclk);
    #2 rst = 1'b0;
    exp_q.push_back(RST_POWER);
    i_lsc_host.rd();
    rdchk(ADDR_GAIN_AND_PERIOD, RST_GAIN_PERIOD);
    for (int a = 2; a < 7; a++) rdchk(4'(a), 8'h00);
    rdchk(4'h8, 8'h00);
    chk(ba, BUS_ADDR_GND);
    i_lsc_host.wr(ADDR_POWER_CONTROL, {6'h00, POWER_UP});
    rdchk(ADDR_POWER_CONTROL, 8'h03);
    chk(pw, 1'b1);
    $display("reset and power test ended");
    for (int p = 0; p < 3; p++) begin
      g = 1'($urandom_range(1));
      i_lsc_host.wr(ADDR_GAIN_AND_PERIOD, {3'h0, g, 2'h0, 2'(p)});
      rdchk(ADDR_GAIN_AND_PERIOD, {3'h0, g, 2'h0, 2'(p)});
      chk(hg, g);
      wdone();
      ch0 = 16'($urandom);
      ch1 = 16'($urandom);
      wdone();
      chk(n + 3 >= (20 << p) && n <= (20 << p) + 1, 1'b1);
      chk(d0, ch0);
      chk(d1, ch1);
    end
    i_lsc_host.wr(ADDR_GAIN_AND_PERIOD, 8'h0B);
    chk(itg, 1'b1);
    i_lsc_host.wr(ADDR_GAIN_AND_PERIOD, 8'h03);
    wdone();
    i_lsc_host.wr(ADDR_GAIN_AND_PERIOD, 8'h00);
    i_lsc_host.put(1'b1, 8'h81);
    exp_q.push_back(8'h00);
    i_lsc_host.rd();
    $display("timing test ended");
    lim[15:0] = 16'($urandom) & 16'h3F7F;
    lim[31:16] = lim[15:0] + 16'h4000;
    i_lsc_host.wrw(ADDR_LOW_LIMIT_LSB, lim[15:0]);
    chk(wm, 1'b1);
    i_lsc_host.wrw(ADDR_HIGH_LIMIT_LSB, lim[31:16]);
    for (int a = 0; a < 4; a++) rdchk(4'(a + 2), lim[a * 8 +: 8]);
    ch0 = lim[15:0] + 16'h0001;
    wdone();
    i_lsc_host.wr(ADDR_ALERT_CONTROL, {2'h0, ALERT_LEVEL, 4'h0});
    i_lsc_host.ptr(1'b1, 1'b0, ADDR_POWER_CONTROL);
    chk(al_n, 1'b1);
    wdone();
    chk(al_n, 1'b0);
    repeat (5) @(posedge mclk);
    chk(al_n, 1'b0);
    i_lsc_host.ptr(1'b1, 1'b0, ADDR_POWER_CONTROL);
    chk(al_n, 1'b1);
    i_lsc_host.wr(ADDR_ALERT_CONTROL, 8'h12);
    ch0 = lim[15:0];
    wdone();
    chk(al_n, 1'b1);
    ch0 = lim[31:16];
    ch1 = lim[31:16] + 16'h0001;
    wdone();
    chk(al_n, 1'b1);
    ch0 = lim[31:16] + 16'h0001;
    wdone();
    chk(al_n, 1'b1);
    wdone();
    chk(al_n, 1'b0);
    i_lsc_host.wr(ADDR_ALERT_CONTROL, 8'h02);
    @(posedge mclk) #2;
    chk(al_n, 1'b1);
    i_lsc_host.wr(ADDR_POWER_CONTROL, {6'h00, POWER_DOWN});
    @(posedge mclk) #2;
    chk(pw, 1'b0);
    $display("alert and power down test ended");
    test_done();
  end
endmodule
bind lsc_regs lsc_regs_assertions i_lsc_regs_assertions (.mclk(mclk), .rst(rst),
  .strap(strap), .wr_byte(wr_byte), .word_mode(word_mode), .powered(powered),
  .integrating(integrating), .conv_done(conv_done), .data_ch0(data_ch0),
  .bus_addr(bus_addr), .alert_n(alert_n));
